//--- shared/comol_pkg.sv
// Package of constants and types for the control output mode logic.
package comol_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses).
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_ALM_OUT   = 8'h04;
	localparam logic [7:0] OFS_RDY_HEAT  = 8'h08;
	localparam logic [7:0] OFS_RDY_COOL  = 8'h0c;
	localparam logic [7:0] OFS_PRESET    = 8'h10;
	localparam logic [7:0] OFS_PID_INIT  = 8'h14;
	localparam logic [7:0] OFS_DIFF      = 8'h18;
	localparam logic [7:0] OFS_OFFSET    = 8'h1c;
	localparam logic [7:0] OFS_SP        = 8'h20;
	localparam logic [7:0] OFS_ITIME     = 8'h24;
	localparam logic [7:0] OFS_DTIME     = 8'h28;
	localparam logic [7:0] OFS_STATUS    = 8'h2c;

	// ----------------------------------------------------------------
	// Control register field positions.
	// ----------------------------------------------------------------
	localparam int B_ONOFF     = 0;
	localparam int B_DIRECT    = 1;
	localparam int B_HEATCOOL  = 2;
	localparam int B_ALM_MODE  = 3;
	localparam int B_XFER_MODE = 4;
	localparam int B_DECIMAL   = 5;
	localparam int B_INIT_LO   = 6;
	localparam int B_INIT_HI   = 7;

	// ----------------------------------------------------------------
	// Values in tenths of a percent, and ranges.
	// ----------------------------------------------------------------
	localparam logic signed [15:0] PCT_MIN    = -16'sd100;
	localparam logic signed [15:0] PCT_MAX    = 16'sd1100;
	localparam logic signed [15:0] PCT_ZERO   = 16'sd0;
	localparam logic signed [15:0] PCT_HALF   = 16'sd500;
	localparam logic signed [15:0] OFS_MIN    = -16'sd1999;
	localparam logic signed [15:0] CNT_MAX    = 16'sd9999;
	localparam logic signed [15:0] DIFF_RST   = 16'sd5;
	localparam logic [31:0]        CTRL_RST   = 32'h0000_0000;
	localparam logic [15:0]        TIME_RST_I = 16'h0078;
	localparam logic [15:0]        TIME_RST_D = 16'h001e;

	// PID re-initialisation policy after a setpoint change.
	typedef enum logic [1:0] {
		INIT_AUTO  = 2'b00,
		INIT_NEVER = 2'b01,
		INIT_ALWAYS = 2'b10
	} comol_init_t;

endpackage

//--- src/comol_top.sv
// Output selection and mode transition logic of a single-loop controller.
`timescale 1ns/1ps
// Function
// - Alarm mode 0 keeps PID on MV; mode 1 forces alarm output value.
// - Process alarm is active when any of three alarm sources occurs.
// - Alarm and READY heat/cool values range -10.0..110.0 %, reset 0.0.
// - Cool READY value accessible only when not ON/OFF and heat/cool on.
// - AUTO to MANUAL: mode 0 holds MV, mode 1 loads preset value.
// - Preset manual default is 0.0 without heat/cool, 50.0 with it.
// - Powering up in MANUAL starts MV from the preset value.
// - Transfer, preset, init mode, init output, decimal need non-ON/OFF.
// - Init mode 0 re-initialises on setpoint change only when judged needed.
// - Init mode 1 never re-initialises on a setpoint change.
// - Init mode 2 re-initialises on every setpoint change.
// - Initial output seeds PID after READY to RUN and at power-up RUN.
// - Heat/cool change rewrites initial output to 50.0 or 0.0.
// - Decimal 0 gives whole seconds, 1 gives tenths, 0..9999 counts.
// - Decimal change keeps stored time counts unchanged.
// - Differential and offset accessible only under ON/OFF control.
// - Reverse action lowers MV as PV rises; direct action raises it.
module comol_top
	import comol_pkg::*;
(
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Process side, from same-clock logic.
	input  wire logic signed [15:0]  process_value,
	input  wire logic signed [15:0]  pid_result,
	input  wire logic                process_alarm_one,
	input  wire logic                process_alarm_two,
	input  wire logic                process_alarm_three,
	input  wire logic                manual_mode,
	input  wire logic                ready_mode,
	input  wire logic                sp_group_change,
	input  wire logic                reinit_needed,
	// Actuator side.
	output logic signed [15:0]       manipulated_variable,
	output logic                     onoff_output,
	output logic                     pid_reinit,
	output logic                     pid_seed,
	output logic signed [15:0]       pid_seed_value,
	output logic [15:0]              integral_ticks,
	output logic [15:0]              derivative_ticks,
	output logic                     time_in_tenths
);
	import comol_pkg::*;

	// ----------------------------------------------------------------
	// Register storage.
	// ----------------------------------------------------------------
	logic [31:0]        ctrl_ff;
	logic signed [15:0] alm_out_ff, rdy_heat_ff, rdy_cool_ff, preset_ff, init_out_ff;
	logic signed [15:0] diff_ff, offset_ff, sp_ff;
	logic [15:0]        itime_ff, dtime_ff;
	logic               started_ff, manual_d_ff, ready_d_ff;

	// ----------------------------------------------------------------
	// Decode and field views.
	// ----------------------------------------------------------------
	wire logic               wr_en     = psel && penable && pwrite;
	wire logic signed [15:0] wval      = pwdata[15:0];
	wire logic               is_onoff  = ctrl_ff[B_ONOFF];
	wire logic               hc_en     = ctrl_ff[B_HEATCOOL];
	wire comol_init_t        init_mode = comol_init_t'(ctrl_ff[B_INIT_HI:B_INIT_LO]);
	wire logic               pct_ok    = (wval >= PCT_MIN) && (wval <= PCT_MAX);
	wire logic               cnt_ok    = (wval >= PCT_ZERO) && (wval <= CNT_MAX);
	wire logic               ofs_ok    = (wval >= OFS_MIN) && (wval <= CNT_MAX);
	wire logic               cool_ok   = !is_onoff && hc_en;
	// Any one of the three sources raises the process alarm.
	wire logic               process_alarm = process_alarm_one || process_alarm_two ||
		process_alarm_three;
	wire logic               wr_ctrl   = wr_en && (paddr == OFS_CTRL);
	// Fields gated by ON/OFF mode keep their value when the write is refused.
	wire logic [31:0] ctrl_wmask = is_onoff ?
		~((32'h0000_0001 << B_XFER_MODE) | (32'h0000_0001 << B_DECIMAL) |
		(32'h0000_0003 << B_INIT_LO)) : 32'hffff_ffff;
	wire logic [31:0] ctrl_new = (ctrl_ff & ~ctrl_wmask) | (pwdata & ctrl_wmask & 32'h0000_00ff);
	// Heat/cool is only changeable outside ON/OFF control.
	wire logic [31:0] ctrl_nxt = is_onoff ?
		{ctrl_new[31:B_HEATCOOL+1], ctrl_ff[B_HEATCOOL], ctrl_new[B_HEATCOOL-1:0]} : ctrl_new;
	wire logic hc_toggle = wr_ctrl && (ctrl_nxt[B_HEATCOOL] != hc_en);
	wire logic signed [15:0] hc_default = ctrl_nxt[B_HEATCOOL] ? PCT_HALF : PCT_ZERO;

	// ----------------------------------------------------------------
	// Register writes; a write takes effect in its access cycle.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_ff     <= CTRL_RST;
			alm_out_ff  <= PCT_ZERO;
			rdy_heat_ff <= PCT_ZERO;
			rdy_cool_ff <= PCT_ZERO;
			preset_ff   <= PCT_ZERO;
			init_out_ff <= PCT_ZERO;
			diff_ff     <= DIFF_RST;
			offset_ff   <= PCT_ZERO;
			sp_ff       <= PCT_ZERO;
			itime_ff    <= TIME_RST_I;
			dtime_ff    <= TIME_RST_D;
		end else if (wr_en) begin
			if (wr_ctrl) ctrl_ff <= ctrl_nxt;
			if (hc_toggle) begin
				preset_ff   <= hc_default;
				init_out_ff <= hc_default;
			end
			if (paddr == OFS_ALM_OUT && pct_ok) alm_out_ff <= wval;
			if (paddr == OFS_RDY_HEAT && pct_ok) rdy_heat_ff <= wval;
			if (paddr == OFS_RDY_COOL && pct_ok && cool_ok) rdy_cool_ff <= wval;
			if (paddr == OFS_PRESET && pct_ok && !is_onoff) preset_ff <= wval;
			if (paddr == OFS_PID_INIT && pct_ok && !is_onoff) init_out_ff <= wval;
			if (paddr == OFS_DIFF && cnt_ok && is_onoff) diff_ff <= wval;
			if (paddr == OFS_OFFSET && ofs_ok && is_onoff) offset_ff <= wval;
			if (paddr == OFS_SP) sp_ff <= wval;
			if (paddr == OFS_ITIME && cnt_ok) itime_ff <= wval;
			if (paddr == OFS_DTIME && cnt_ok) dtime_ff <= wval;
		end
	end

	// ----------------------------------------------------------------
	// Read mux; unmapped addresses read zero with an error.
	// ----------------------------------------------------------------
	wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
	wire logic [31:0] status_word = {24'h00_0000, 2'b00, pid_reinit, pid_seed,
		started_ff, process_alarm, onoff_output, ready_mode};
	logic [31:0] rd_mux;
	always_comb begin
		unique case (paddr)
			OFS_CTRL:     rd_mux = ctrl_ff;
			OFS_ALM_OUT:  rd_mux = {{16{alm_out_ff[15]}}, alm_out_ff};
			OFS_RDY_HEAT: rd_mux = {{16{rdy_heat_ff[15]}}, rdy_heat_ff};
			OFS_RDY_COOL: rd_mux = {{16{rdy_cool_ff[15]}}, rdy_cool_ff};
			OFS_PRESET:   rd_mux = {{16{preset_ff[15]}}, preset_ff};
			OFS_PID_INIT: rd_mux = {{16{init_out_ff[15]}}, init_out_ff};
			OFS_DIFF:     rd_mux = {16'h0000, diff_ff};
			OFS_OFFSET:   rd_mux = {{16{offset_ff[15]}}, offset_ff};
			OFS_SP:       rd_mux = {{16{sp_ff[15]}}, sp_ff};
			OFS_ITIME:    rd_mux = {16'h0000, itime_ff};
			OFS_DTIME:    rd_mux = {16'h0000, dtime_ff};
			OFS_STATUS:   rd_mux = status_word;
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// APB answer: pready high in every access cycle, zero wait states.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Event detection.
	// ----------------------------------------------------------------
	wire logic sp_written   = wr_en && (paddr == OFS_SP) && (wval != sp_ff);
	wire logic sp_change    = sp_written || sp_group_change;
	wire logic to_manual    = manual_mode && !manual_d_ff && started_ff;
	wire logic to_run       = (!ready_mode && ready_d_ff) || (!started_ff && !ready_mode);
	wire logic power_manual = !started_ff && manual_mode;

	// Re-initialisation decision per policy.
	logic do_reinit;
	always_comb begin
		unique case (init_mode)
			INIT_AUTO:   do_reinit = sp_change && reinit_needed;
			INIT_NEVER:  do_reinit = 1'b0;
			INIT_ALWAYS: do_reinit = sp_change;
			default:     do_reinit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// ON/OFF hysteresis; the switch point is setpoint plus offset.
	// ----------------------------------------------------------------
	wire logic signed [17:0] pv_x   = 18'(process_value);
	wire logic signed [17:0] point  = 18'(sp_ff) + 18'(offset_ff);
	wire logic signed [17:0] low_pt = point - 18'(diff_ff);
	wire logic signed [17:0] hi_pt  = point + 18'(diff_ff);
	wire logic direct = ctrl_ff[B_DIRECT];
	// Reverse: off at or above point, on below point minus differential.
	// Direct: off at or below point, on above point plus differential.
	wire logic rev_on  = (pv_x < low_pt);
	wire logic rev_off = (pv_x >= point);
	wire logic dir_on  = (pv_x > hi_pt);
	wire logic dir_off = (pv_x <= point);
	wire logic sw_on   = direct ? dir_on : rev_on;
	wire logic sw_off  = direct ? dir_off : rev_off;
	wire logic nxt_onoff = ready_mode ? 1'b0 : sw_on ? 1'b1 : sw_off ? 1'b0 : onoff_output;

	// ----------------------------------------------------------------
	// MV source selection, READY first, then manual, then ON/OFF, then alarm, then PID.
	// ----------------------------------------------------------------
	wire logic signed [15:0] ready_val = (hc_en && direct) ? rdy_cool_ff : rdy_heat_ff;
	wire logic signed [15:0] onoff_mv  = onoff_output ? 16'sd1000 : PCT_ZERO;
	wire logic signed [15:0] auto_mv   = is_onoff ? onoff_mv :
		(ctrl_ff[B_ALM_MODE] && process_alarm) ? alm_out_ff : pid_result;
	wire logic xfer_preset = ctrl_ff[B_XFER_MODE] && !is_onoff;
	wire logic signed [15:0] nxt_mv =
		ready_mode ? ready_val :
		power_manual ? preset_ff :
		to_manual ? (xfer_preset ? preset_ff : manipulated_variable) :
		manual_mode ? manipulated_variable : auto_mv;

	// Output and history flops; manual MV is held until software adds a path.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			manipulated_variable <= PCT_ZERO;
			onoff_output         <= 1'b0;
			pid_reinit           <= 1'b0;
			pid_seed             <= 1'b0;
			pid_seed_value       <= PCT_ZERO;
			started_ff           <= 1'b0;
			manual_d_ff          <= 1'b0;
			ready_d_ff           <= 1'b1;
		end else begin
			manipulated_variable <= nxt_mv;
			onoff_output         <= is_onoff ? nxt_onoff : 1'b0;
			pid_reinit           <= do_reinit && !is_onoff;
			pid_seed             <= to_run && !manual_mode;
			pid_seed_value       <= init_out_ff;
			started_ff           <= 1'b1;
			manual_d_ff          <= manual_mode;
			ready_d_ff           <= ready_mode;
		end
	end

	// Time counts pass through unchanged; only their unit follows the decimal bit.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			integral_ticks   <= TIME_RST_I;
			derivative_ticks <= TIME_RST_D;
			time_in_tenths   <= 1'b0;
		end else begin
			integral_ticks   <= itime_ff;
			derivative_ticks <= dtime_ff;
			time_in_tenths   <= ctrl_ff[B_DECIMAL];
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	a_alarm_forces_mv: assert property (@(posedge ref_clk) disable iff (rst)
		(!ready_mode && !manual_mode && started_ff && !is_onoff && process_alarm &&
		ctrl_ff[B_ALM_MODE]) |=> (manipulated_variable == $past(alm_out_ff)))
		else $error("MV not forced to alarm value.");
	a_alarm_any_src: assert property (@(posedge ref_clk) disable iff (rst)
		(!ready_mode && !manual_mode && started_ff && !is_onoff && ctrl_ff[B_ALM_MODE] &&
		!process_alarm_one && !process_alarm_two && !process_alarm_three) |=>
		(manipulated_variable == $past(pid_result)))
		else $error("MV left the PID result with no alarm source active.");
	a_pct_range: assert property (@(posedge ref_clk) disable iff (rst)
		(alm_out_ff >= PCT_MIN) && (alm_out_ff <= PCT_MAX) &&
		(rdy_heat_ff >= PCT_MIN) && (rdy_heat_ff <= PCT_MAX) &&
		(rdy_cool_ff >= PCT_MIN) && (rdy_cool_ff <= PCT_MAX))
		else $error("Percent value out of range.");
	a_cool_locked: assert property (@(posedge ref_clk) disable iff (rst)
		!cool_ok |=> $stable(rdy_cool_ff))
		else $error("Cool READY value changed while locked.");
	a_bumpless_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(to_manual && !ready_mode && !xfer_preset) |=> $stable(manipulated_variable))
		else $error("Bumpless transfer moved MV.");
	a_preset_load: assert property (@(posedge ref_clk) disable iff (rst)
		(to_manual && !ready_mode && xfer_preset) |=> manipulated_variable == $past(preset_ff))
		else $error("Preset not loaded on manual change.");
	a_no_reinit_never: assert property (@(posedge ref_clk) disable iff (rst)
		(init_mode == INIT_NEVER) |=> !pid_reinit)
		else $error("Reinit under never policy.");
	a_reinit_always: assert property (@(posedge ref_clk) disable iff (rst)
		(init_mode == INIT_ALWAYS && sp_change && !is_onoff) |=> pid_reinit)
		else $error("Missed reinit under always policy.");
	a_hc_rewrite: assert property (@(posedge ref_clk) disable iff (rst)
		hc_toggle |=> (init_out_ff == (hc_en ? PCT_HALF : PCT_ZERO)))
		else $error("Initial output not rewritten.");
	a_onoff_locked: assert property (@(posedge ref_clk) disable iff (rst)
		!is_onoff |=> $stable(diff_ff) && $stable(offset_ff))
		else $error("ON/OFF setting changed outside ON/OFF.");
	a_ready_wins: assert property (@(posedge ref_clk) disable iff (rst)
		(ready_mode && !hc_en) |=> manipulated_variable == $past(rdy_heat_ff))
		else $error("READY value not on MV.");
	a_rev_off: assert property (@(posedge ref_clk) disable iff (rst)
		(is_onoff && !direct && !ready_mode && rev_off) |=> !onoff_output)
		else $error("Reverse output not off above point.");
	a_power_manual: assert property (@(posedge ref_clk) disable iff (rst)
		(!started_ff && manual_mode && !ready_mode) |=>
		(manipulated_variable == $past(preset_ff)))
		else $error("Power-up in MANUAL did not start from the preset.");
	a_power_seed: assert property (@(posedge ref_clk) disable iff (rst)
		(!started_ff && !ready_mode && !manual_mode) |=> pid_seed)
		else $error("No seed at power-up into RUN.");
	a_seed_value: assert property (@(posedge ref_clk) disable iff (rst)
		pid_seed |-> (pid_seed_value == $past(init_out_ff)))
		else $error("Seed value is not the initial output.");
	a_reinit_auto: assert property (@(posedge ref_clk) disable iff (rst)
		(init_mode == INIT_AUTO && !is_onoff) |=>
		(pid_reinit == $past(sp_change && reinit_needed)))
		else $error("Auto policy reinit does not follow the judgement.");
	a_decimal_unit: assert property (@(posedge ref_clk) disable iff (rst)
		time_in_tenths == $past(ctrl_ff[B_DECIMAL]))
		else $error("Time unit does not follow the decimal setting.");
	a_ticks_kept: assert property (@(posedge ref_clk) disable iff (rst)
		(integral_ticks == $past(itime_ff)) && (derivative_ticks == $past(dtime_ff)))
		else $error("Time counts altered on the way out.");

endmodule // comol_top

//--- dv/comol_plant.sv
// Process sensor and alarm source model facing the output logic.
`timescale 1ns/1ps
module comol_plant (
	// Clock and reset.
	input  wire logic               ref_clk,
	input  wire logic               rst,
	// Commands from the bench.
	input  wire logic signed [15:0] pv_cmd,
	input  wire logic [2:0]         alarm_cmd,
	// Sensor side.
	output logic signed [15:0]      process_value,
	output logic [2:0]              alarms
);
	// The sensor reports one sample late, as a real converter would.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			process_value <= 16'sh0000;
			alarms        <= 3'h0;
		end else begin
			process_value <= pv_cmd;
			alarms        <= alarm_cmd;
		end
	end
endmodule // comol_plant

//--- dv/test_control_output_mode_logic.sv
// Self-checking bench for the control output mode logic.
`timescale 1ns/1ps
module test_control_output_mode_logic;
	import comol_pkg::*;
	// ----------------------------------------------------------------
	// Signals and instances.
	// ----------------------------------------------------------------
	logic               ref_clk = 1'b0;
	logic               rst = 1'b1;
	logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0, prdata, rd_v;
	logic               pready, pslverr, rd_e, st;
	logic signed [15:0] pv_cmd = 16'sh0000, pid_result = 16'sh0000;
	logic signed [15:0] process_value, mv, seed_val, v1, v2, v3;
	logic [2:0]         alarm_cmd = 3'h0, alarms;
	logic               manual_mode = 1'b0, ready_mode = 1'b0;
	logic               sp_group_change = 1'b0, reinit_needed = 1'b0;
	logic               onoff_output, pid_reinit, pid_seed, time_in_tenths;
	logic [15:0]        integral_ticks, derivative_ticks;
	int                 n_fail = 0, samples_checked = 0, cycles = 0;
	int                 seeds = 0, reinits = 0, n0, p, sw, df;
	logic [7:0]         ra [10] = '{OFS_CTRL, OFS_ALM_OUT, OFS_RDY_HEAT, OFS_RDY_COOL,
		OFS_PRESET, OFS_PID_INIT, OFS_DIFF, OFS_OFFSET, OFS_ITIME, OFS_DTIME};
	logic [31:0]        rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5,
		32'h0, 32'h0000_0078, 32'h0000_001e};

	comol_top comol_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .process_value(process_value), .pid_result(pid_result),
		.process_alarm_one(alarms[0]), .process_alarm_two(alarms[1]),
		.process_alarm_three(alarms[2]), .manual_mode(manual_mode),
		.ready_mode(ready_mode), .sp_group_change(sp_group_change),
		.reinit_needed(reinit_needed), .manipulated_variable(mv),
		.onoff_output(onoff_output), .pid_reinit(pid_reinit), .pid_seed(pid_seed),
		.pid_seed_value(seed_val), .integral_ticks(integral_ticks),
		.derivative_ticks(derivative_ticks), .time_in_tenths(time_in_tenths));
	comol_plant comol_plant_i (.ref_clk(ref_clk), .rst(rst), .pv_cmd(pv_cmd),
		.alarm_cmd(alarm_cmd), .process_value(process_value), .alarms(alarms));

	// Free-running 125 MHz clock.
	always #4 ref_clk = ~ref_clk;

	// Pulse counters, so single-cycle outputs are never missed, and the hang guard.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (pid_seed === 1'b1) seeds <= seeds + 1;
		if (pid_reinit === 1'b1) reinits <= reinits + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// Helpers.
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; it waits for pready rather than assuming a latency.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) chk("pready", 32'h1, 32'h0);
		rd_v = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Lets the sensor delay and the registered outputs catch up.
	task automatic settle();
		repeat (4) @(posedge ref_clk);
	endtask

	// Expected ON/OFF state; sw is setpoint plus offset, df the differential.
	function automatic logic onoff_exp(input logic dir, input logic prev,
		input int p, input int sw, input int df);
		if (!dir && p >= sw) return 1'b0;
		if (!dir && p < sw - df) return 1'b1;
		if (dir && p <= sw) return 1'b0;
		if (dir && p > sw + df) return 1'b1;
		return prev;
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Stimulus.
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(3368));
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rv[i], rd_v);
		end
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped error", 32'h1, 32'(rd_e));
		chk("derivative ticks", 32'(TIME_RST_D), 32'(derivative_ticks));
		v1 = 16'($urandom_range(1200) - 100);
		v2 = 16'($urandom_range(1200) - 100);
		v3 = 16'($urandom_range(1200) - 100);
		pid_result <= v2;
		apb(1'b1, OFS_ALM_OUT, 32'(v1));
		apb(1'b1, OFS_CTRL, 32'h0000_0008);
		for (int i = 0; i < 3; i++) begin
			alarm_cmd <= 3'(1 << i);
			settle();
			chk("mv at alarm", 32'(v1), 32'(mv));
			alarm_cmd <= 3'h0;
			settle();
			chk("mv no alarm", 32'(v2), 32'(mv));
		end
		apb(1'b1, OFS_CTRL, 32'h0);
		alarm_cmd <= 3'h7;
		settle();
		chk("mv alarm mode 0", 32'(v2), 32'(mv));
		apb(1'b1, OFS_ALM_OUT, 32'h0000_044d);
		apb(1'b0, OFS_ALM_OUT, 32'h0);
		chk("alarm out range", 32'(v1), rd_v);
		apb(1'b1, OFS_RDY_HEAT, 32'(v3));
		apb(1'b1, OFS_CTRL, 32'h0000_0008);
		ready_mode <= 1'b1;
		settle();
		chk("mv ready heat", 32'(v3), 32'(mv));
		apb(1'b1, OFS_RDY_COOL, 32'(v1));
		apb(1'b0, OFS_RDY_COOL, 32'h0);
		chk("cool locked", 32'h0, rd_v);
		apb(1'b1, OFS_CTRL, 32'h0000_000e);
		apb(1'b0, OFS_PRESET, 32'h0);
		chk("preset hc", 32'(PCT_HALF), rd_v);
		apb(1'b0, OFS_PID_INIT, 32'h0);
		chk("init out hc", 32'(PCT_HALF), rd_v);
		apb(1'b1, OFS_RDY_COOL, 32'(v1));
		apb(1'b0, OFS_RDY_COOL, 32'h0);
		chk("cool open", 32'(v1), rd_v);
		settle();
		chk("mv ready cool", 32'(v1), 32'(mv));
		apb(1'b1, OFS_PID_INIT, 32'(v2));
		n0 = seeds;
		alarm_cmd <= 3'h0;
		ready_mode <= 1'b0;
		settle();
		chk("seed pulses", 32'h1, 32'(seeds - n0));
		chk("seed value", 32'(v2), 32'(seed_val));
		apb(1'b1, OFS_CTRL, 32'h0000_0014);
		apb(1'b1, OFS_PRESET, 32'(v3));
		manual_mode <= 1'b1;
		settle();
		chk("mv preset", 32'(v3), 32'(mv));
		manual_mode <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h0000_0004);
		settle();
		manual_mode <= 1'b1;
		pid_result <= v1;
		settle();
		chk("mv bumpless", 32'(v2), 32'(mv));
		manual_mode <= 1'b0;
		apb(1'b1, OFS_DIFF, 32'h9);
		apb(1'b0, OFS_DIFF, 32'h0);
		chk("diff locked", 32'h5, rd_v);
		v1 = 16'($urandom_range(9999));
		apb(1'b1, OFS_ITIME, 32'(v1));
		for (int k = 1; k >= 0; k--) begin
			apb(1'b1, OFS_CTRL, 32'(k << 5) | 32'h4);
			settle();
			chk("tenths", 32'(k), 32'(time_in_tenths));
			chk("integral kept", 32'(v1), 32'(integral_ticks));
		end
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFS_CTRL, 32'(m << 6) | 32'h4);
			for (int r = 0; r < 2; r++) begin
				n0 = reinits;
				reinit_needed <= r[0];
				sp_group_change <= 1'b1;
				@(posedge ref_clk);
				sp_group_change <= 1'b0;
				settle();
				chk("reinit", 32'(m == 2 || (m == 0 && r == 1)), 32'(reinits - n0));
			end
		end
		n0 = reinits;
		apb(1'b1, OFS_CTRL, 32'h0000_0084);
		apb(1'b1, OFS_SP, 32'h0000_0064);
		settle();
		chk("reinit on sp write", 32'h1, 32'(reinits - n0));
		apb(1'b1, OFS_CTRL, 32'h0);
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, OFS_CTRL, 32'(d << 1) | 32'h1);
			apb(1'b1, OFS_PRESET, 32'(v3));
			apb(1'b0, OFS_PRESET, 32'h0);
			chk("preset locked", 32'h0, rd_v);
			apb(1'b1, OFS_DIFF, d ? 32'h5 : 32'hf);
			apb(1'b1, OFS_OFFSET, d ? 32'hffff_fffb : 32'h5);
			apb(1'b1, OFS_SP, d ? 32'ha : 32'hc8);
			apb(1'b0, OFS_DIFF, 32'h0);
			chk("diff open", d ? 32'h5 : 32'hf, rd_v);
			sw = d ? 5 : 205;
			df = d ? 5 : 15;
			st = 1'b0;
			for (int k = 0; k < 30; k++) begin
				p = (k == 0) ? sw + (d ? -50 : 50) : sw - 30 + int'($urandom_range(60));
				pv_cmd <= 16'(p);
				st = onoff_exp(d[0], st, p, sw, df);
				settle();
				chk("onoff", 32'(st), 32'(onoff_output));
				chk("onoff mv", st ? 32'h3e8 : 32'h0, 32'(mv));
			end
		end
		// Mid-run resets: power-up in MANUAL takes the preset, power-up in RUN seeds once.
		for (int u = 0; u < 2; u++) begin
			n0 = seeds;
			manual_mode <= (u == 0);
			rst <= 1'b1;
			repeat (12) @(posedge ref_clk);
			rst <= 1'b0;
			settle();
			chk("power-up seeds", 32'(u), 32'(seeds - n0));
			chk("power-up mv", u ? 32'(pid_result) : 32'(PCT_ZERO), 32'(mv));
		end
		end_of_test();
	end
endmodule // test_control_output_mode_logic
